// File: common/capsns_defs.svh
`ifndef CAPSNS_DEFS_SVH
`define CAPSNS_DEFS_SVH

// register addresses in the special function register space
`define CAPSNS_ADDR_CTRL 8'h9A
`define CAPSNS_ADDR_CFG 8'h9E
`define CAPSNS_ADDR_MUX 8'h9C
`define CAPSNS_ADDR_SCAN 8'h9D
`define CAPSNS_ADDR_THR_LO 8'h96
`define CAPSNS_ADDR_THR_HI 8'h97
`define CAPSNS_ADDR_RES_LO 8'hED
`define CAPSNS_ADDR_RES_HI 8'hEE

// control register bits
`define CAPSNS_CTRL_EN 7
`define CAPSNS_CTRL_DONE 5
`define CAPSNS_CTRL_BUSY 4
`define CAPSNS_CTRL_THR 3

// configuration register fields
`define CAPSNS_CFG_MODE_HI 6
`define CAPSNS_CFG_MODE_LO 4
`define CAPSNS_CFG_ACU_HI 2
`define CAPSNS_CFG_ACU_LO 0
`define CAPSNS_CFG_WMASK 8'h77

// scan register fields: first channel low nibble, last channel high nibble
`define CAPSNS_SCAN_FIRST_HI 3
`define CAPSNS_SCAN_FIRST_LO 0
`define CAPSNS_SCAN_LAST_HI 7
`define CAPSNS_SCAN_LAST_LO 4

// reset values
`define CAPSNS_RST_BYTE 8'h00
`define CAPSNS_RST_WORD 16'h0000
`define CAPSNS_RST_SCAN 8'hF0

`endif

// File: common/capsns_pkg.sv
`default_nettype none

package capsns_pkg;

   typedef enum logic [2:0] {
      CAPSNS_SOC_SOFTWARE = 3'h0,
      CAPSNS_SOC_TIMER0 = 3'h1,
      CAPSNS_SOC_TIMER2 = 3'h2,
      CAPSNS_SOC_TIMER1 = 3'h3,
      CAPSNS_SOC_RSVD4 = 3'h4,
      CAPSNS_SOC_RSVD5 = 3'h5,
      CAPSNS_SOC_CONT = 3'h6,
      CAPSNS_SOC_SCAN = 3'h7
   } capsns_mode_t;

   typedef enum logic [1:0] {
      CAPSNS_ST_OFF,
      CAPSNS_ST_IDLE,
      CAPSNS_ST_CONV
   } capsns_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } capsns_sfr_req_t;

   typedef struct packed {
      logic done;
      logic [15:0] value;
   } capsns_afe_t;

   typedef struct packed {
      logic tmr0;
      logic tmr1;
      logic tmr2;
   } capsns_tmr_t;

endpackage

`default_nettype wire

// File: core/capsns_sequencer.sv
// What this block does
// - The unit works only while its enable bit is 1 and otherwise sits powered down.
// - The channel multiplexer selects among at most 16 channels, fewer on smaller parts.
// - The unit measures either one selected pin or a range of pins visited by auto-scan.
// - An event is raised when a conversion completes and another on a threshold crossing.
// - Start mode 000 begins one conversion for every write of 1 to the busy bit made while idle; writes during a conversion are ignored.
// - Start modes 001, 010 and 011 start on Timer 0, Timer 2 and Timer 1 overflow.
// - Start mode 110 converts back to back after software writes 1 to the busy bit.
// - Start mode 111 converts continuously with auto-scan after a write of 1 to busy.
// - The accumulate field sums 1, 4, 8, 16, 32 or 64 samples; codes 11x are reserved.
// - Configuration bits 7 and 3 read as zero and ignore writes.
// - The channel select register is written by firmware and also stepped by auto-scan.
`timescale 1ns/1ps
`include "capsns_defs.svh"
`default_nettype none

module capsns_sequencer
   import capsns_pkg::*;
#(
   parameter int NUM_CHANNELS = 16,
   parameter int ACC_WIDTH = 22
)
(
   // clock, reset, clock enable
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // special function register access
   input wire capsns_pkg::capsns_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // timer overflow pulses
   input wire capsns_pkg::capsns_tmr_t tmr_ovf,
   // capacitance-to-digital front end
   input wire capsns_pkg::capsns_afe_t afe_in,
   output logic afe_power_on,
   output logic afe_start,
   output logic [3:0] mux_sel,
   // event flags toward the interrupt controller
   output logic done_event,
   output logic thr_event
);

   import capsns_pkg::*;

   // maps the accumulate code to a log2 sample count; reserved codes act as one sample
   function automatic logic [2:0] acu_shift(input logic [2:0] code);
      logic [2:0] s;
      s = 3'h0;
      case (code)
         3'h1: s = 3'h2;
         3'h2: s = 3'h3;
         3'h3: s = 3'h4;
         3'h4: s = 3'h5;
         3'h5: s = 3'h6;
         default: s = 3'h0;
      endcase
      return s;
   endfunction

   // next channel of the scan range; an out-of-range channel restarts at the first
   function automatic logic [3:0] scan_next(input logic [3:0] cur, input logic [3:0] first,
                                            input logic [3:0] last);
      logic [3:0] n;
      n = first;
      if ((cur >= first) && (cur < last))
      begin
         n = cur + 4'h1;
      end
      return n;
   endfunction

   capsns_state_t state_q, state_d;
   logic [7:0] ctrl_en_q;
   logic [7:0] cfg_q;
   logic [3:0] mux_q, mux_d;
   logic [7:0] scan_q;
   logic [15:0] thr_q;
   logic [15:0] res_q;
   logic [ACC_WIDTH-1:0] acc_q, acc_d;
   logic [6:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic cont_q, cont_d;
   logic done_q, thr_flag_q;
   logic above_q;
   logic start_q;
   logic power_q;
   logic [7:0] rdata_q;

   // decode
   wire logic wr_ctrl = sfr_req.wr && (sfr_req.addr == `CAPSNS_ADDR_CTRL);
   wire logic wr_cfg = sfr_req.wr && (sfr_req.addr == `CAPSNS_ADDR_CFG);
   wire logic wr_mux = sfr_req.wr && (sfr_req.addr == `CAPSNS_ADDR_MUX);
   wire logic wr_scan = sfr_req.wr && (sfr_req.addr == `CAPSNS_ADDR_SCAN);
   wire logic wr_thr_lo = sfr_req.wr && (sfr_req.addr == `CAPSNS_ADDR_THR_LO);
   wire logic wr_thr_hi = sfr_req.wr && (sfr_req.addr == `CAPSNS_ADDR_THR_HI);

   wire logic enabled = ctrl_en_q[`CAPSNS_CTRL_EN];
   wire capsns_mode_t mode = capsns_mode_t'(cfg_q[`CAPSNS_CFG_MODE_HI:`CAPSNS_CFG_MODE_LO]);
   wire logic [2:0] shift = acu_shift(cfg_q[`CAPSNS_CFG_ACU_HI:`CAPSNS_CFG_ACU_LO]);
   wire logic [6:0] last_idx = 7'((8'h01 << shift) - 8'h01);
   wire logic [3:0] scan_first = scan_q[`CAPSNS_SCAN_FIRST_HI:`CAPSNS_SCAN_FIRST_LO];
   wire logic [3:0] scan_last = scan_q[`CAPSNS_SCAN_LAST_HI:`CAPSNS_SCAN_LAST_LO];

   // software start: one shot in mode 000, arms repetition in 110 and 111
   wire logic busy_wr1 = wr_ctrl && sfr_req.wdata[`CAPSNS_CTRL_BUSY];
   wire logic busy_wr0 = wr_ctrl && !sfr_req.wdata[`CAPSNS_CTRL_BUSY];
   wire logic is_cont = (mode == CAPSNS_SOC_CONT) || (mode == CAPSNS_SOC_SCAN);
   wire logic sw_trig = busy_wr1 && ((mode == CAPSNS_SOC_SOFTWARE) || is_cont);
   wire logic tmr_trig = ((mode == CAPSNS_SOC_TIMER0) && tmr_ovf.tmr0)
                       || ((mode == CAPSNS_SOC_TIMER2) && tmr_ovf.tmr2)
                       || ((mode == CAPSNS_SOC_TIMER1) && tmr_ovf.tmr1);
   // reserved modes 100 and 101 produce no trigger at all
   wire logic trig = sw_trig || tmr_trig || cont_q;
   wire logic scan_on = (mode == CAPSNS_SOC_SCAN);

   // accumulation and result
   // a sample arriving in the cycle that enable drops is discarded with the batch
   wire logic sample_in = enabled && (state_q == CAPSNS_ST_CONV) && afe_in.done;
   wire logic [ACC_WIDTH-1:0] acc_sum = acc_q + ACC_WIDTH'(afe_in.value);
   wire logic final_sample = sample_in && (cnt_q == last_idx);
   wire logic [15:0] res_new = 16'(acc_sum >> shift);
   wire logic now_above = (res_new >= thr_q);
   wire logic crossing = final_sample && (now_above != above_q);

   // flags: a hardware set in the same cycle as a software clear wins
   wire logic done_clr = wr_ctrl && !sfr_req.wdata[`CAPSNS_CTRL_DONE];
   wire logic thr_clr = wr_ctrl && !sfr_req.wdata[`CAPSNS_CTRL_THR];
   wire logic done_d = final_sample || (done_q && !done_clr);
   wire logic thr_flag_d = crossing || (thr_flag_q && !thr_clr);

   // firmware channel writes beyond the fitted channels are dropped
   wire logic mux_ok = 32'(sfr_req.wdata[3:0]) < NUM_CHANNELS;

   // a scan range reaching past the fitted channels falls back to channel 0
   wire logic [3:0] scan_nxt = scan_next(mux_q, scan_first, scan_last);
   wire logic [3:0] scan_step = (32'(scan_nxt) < NUM_CHANNELS) ? scan_nxt : 4'h0;

   always_comb
   begin
      state_d = state_q;
      acc_d = acc_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      cont_d = cont_q;
      mux_d = mux_q;
      if (wr_mux && mux_ok)
      begin
         mux_d = sfr_req.wdata[3:0];
      end
      if (busy_wr1 && is_cont)
      begin
         cont_d = 1'b1;
      end
      // writing 0 to busy or leaving the repeating modes stops repetition
      if (busy_wr0 || !is_cont)
      begin
         cont_d = 1'b0;
      end
      case (state_q)
         CAPSNS_ST_OFF:
         begin
            busy_d = 1'b0;
            cont_d = 1'b0;
            if (enabled)
            begin
               state_d = CAPSNS_ST_IDLE;
            end
         end
         CAPSNS_ST_IDLE:
         begin
            if (trig)
            begin
               state_d = CAPSNS_ST_CONV;
               busy_d = 1'b1;
               acc_d = '0;
               cnt_d = 7'h00;
            end
         end
         CAPSNS_ST_CONV:
         begin
            if (sample_in)
            begin
               acc_d = acc_sum;
               cnt_d = cnt_q + 7'h01;
            end
            if (final_sample)
            begin
               state_d = CAPSNS_ST_IDLE;
               busy_d = 1'b0;
               if (scan_on)
               begin
                  mux_d = scan_step;
               end
            end
         end
         default:
         begin
            state_d = CAPSNS_ST_OFF;
         end
      endcase
      // clearing enable aborts any measurement and powers down
      if (!enabled)
      begin
         state_d = CAPSNS_ST_OFF;
         busy_d = 1'b0;
         cont_d = 1'b0;
      end
   end

   // a start pulse for the first sample and for every further one of a batch
   wire logic start_d = (enabled && (state_q == CAPSNS_ST_IDLE) && trig)
                      || (enabled && sample_in && !final_sample);

   // readback; reserved bits come back as zero
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      case (sfr_req.addr)
         `CAPSNS_ADDR_CTRL: rd_mux = {enabled, 1'b0, done_q, busy_q, thr_flag_q, 3'h0};
         `CAPSNS_ADDR_CFG: rd_mux = cfg_q & `CAPSNS_CFG_WMASK;
         `CAPSNS_ADDR_MUX: rd_mux = {4'h0, mux_q};
         `CAPSNS_ADDR_SCAN: rd_mux = scan_q;
         `CAPSNS_ADDR_THR_LO: rd_mux = thr_q[7:0];
         `CAPSNS_ADDR_THR_HI: rd_mux = thr_q[15:8];
         `CAPSNS_ADDR_RES_LO: rd_mux = res_q[7:0];
         `CAPSNS_ADDR_RES_HI: rd_mux = res_q[15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_q <= CAPSNS_ST_OFF;
         ctrl_en_q <= `CAPSNS_RST_BYTE;
         cfg_q <= `CAPSNS_RST_BYTE;
         mux_q <= 4'h0;
         scan_q <= `CAPSNS_RST_SCAN;
         thr_q <= `CAPSNS_RST_WORD;
         res_q <= `CAPSNS_RST_WORD;
         acc_q <= '0;
         cnt_q <= 7'h00;
         busy_q <= 1'b0;
         cont_q <= 1'b0;
         done_q <= 1'b0;
         thr_flag_q <= 1'b0;
         above_q <= 1'b0;
         start_q <= 1'b0;
         power_q <= 1'b0;
         rdata_q <= `CAPSNS_RST_BYTE;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         cont_q <= cont_d;
         mux_q <= mux_d;
         done_q <= done_d;
         thr_flag_q <= thr_flag_d;
         start_q <= start_d;
         power_q <= (state_d != CAPSNS_ST_OFF);
         rdata_q <= rd_mux;
         if (wr_ctrl)
         begin
            ctrl_en_q <= sfr_req.wdata & 8'h80;
         end
         if (wr_cfg)
         begin
            cfg_q <= sfr_req.wdata & `CAPSNS_CFG_WMASK;
         end
         if (wr_scan)
         begin
            scan_q <= sfr_req.wdata;
         end
         if (wr_thr_lo)
         begin
            thr_q[7:0] <= sfr_req.wdata;
         end
         if (wr_thr_hi)
         begin
            thr_q[15:8] <= sfr_req.wdata;
         end
         if (final_sample)
         begin
            res_q <= res_new;
            above_q <= now_above;
         end
      end
   end

   assign sfr_rdata = rdata_q;
   assign afe_power_on = power_q;
   assign afe_start = start_q;
   assign mux_sel = mux_q;
   assign done_event = done_q;
   assign thr_event = thr_flag_q;

endmodule

`default_nettype wire

// File: testbench/capsns_sequencer_sva.sv
`timescale 1ns/1ps
`include "capsns_defs.svh"
`default_nettype none
module capsns_sequencer_sva
   import capsns_pkg::*;
#(
   parameter int NUM_CHANNELS = 16
)
(
   // clock
   input wire logic core_clk,
   input wire logic reset,
   // registers
   input wire capsns_pkg::capsns_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   // conversion
   input wire capsns_pkg::capsns_tmr_t tmr_ovf,
   input wire capsns_pkg::capsns_afe_t afe_in,
   input wire logic afe_power_on,
   input wire logic afe_start,
   input wire logic [3:0] mux_sel,
   input wire logic done_event,
   input wire logic thr_event
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   wire ctl_wr = sfr_req.wr && sfr_req.addr == `CAPSNS_ADDR_CTRL;
   wire en_wr = ctl_wr && sfr_req.wdata[`CAPSNS_CTRL_EN];
   wire mux_wr = sfr_req.wr && sfr_req.addr == `CAPSNS_ADDR_MUX;
   wire cfg_rd = sfr_req.addr == `CAPSNS_ADDR_CFG;
   wire tmr_hit = |tmr_ovf;
   wire smp = afe_in.done;
   // power decode sits behind the enable flop, so power rises two edges after the write
   power_up_a:
      assert property ($rose(afe_power_on) |-> $past(en_wr) || $past(en_wr, 2))
      else $error("power up without enable write");
   start_power_a:
      assert property (afe_start |-> afe_power_on)
      else $error("sample request while powered down");
   mux_range_a:
      assert property (mux_sel < NUM_CHANNELS)
      else $error("channel out of range");
   mux_cause_a:
      assert property (!$stable(mux_sel) |-> $past(mux_wr) || $past(smp))
      else $error("channel moved without write or sample");
   start_cause_a:
      assert property ($rose(afe_start) |-> $past(ctl_wr) || $past(tmr_hit) || $past(smp)
         || $past(smp, 2))
      else $error("sample request without trigger");
   done_cause_a:
      assert property ($rose(done_event) |-> $past(smp))
      else $error("done without sample");
   thr_cause_a:
      assert property ($rose(thr_event) |-> $past(smp))
      else $error("threshold flag without sample");
   flag_clear_a:
      assert property ($fell(done_event) || $fell(thr_event) |-> $past(ctl_wr) || $past(reset))
      else $error("flag cleared without control write");
   cfg_zero_a:
      assert property (cfg_rd |=> !sfr_rdata[7] && !sfr_rdata[3])
      else $error("config unused bit reads one");
endmodule
bind capsns_sequencer capsns_sequencer_sva #(.NUM_CHANNELS(NUM_CHANNELS)) u_capsns_sva (
   .core_clk, .reset, .sfr_req, .sfr_rdata, .tmr_ovf, .afe_in, .afe_power_on, .afe_start,
   .mux_sel, .done_event, .thr_event);
`default_nettype wire

// File: testbench/capsns_sequencer_bench.sv
`timescale 1ns/1ps
`include "capsns_defs.svh"
`default_nettype none
module capsns_sequencer_bench;
   import capsns_pkg::*;
   localparam logic [7:0] CTL = `CAPSNS_ADDR_CTRL;
   localparam logic [7:0] CFG = `CAPSNS_ADDR_CFG;
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic clk_en = 1'h1;
   capsns_sfr_req_t req = '0;
   capsns_tmr_t tmr = '0;
   capsns_afe_t afe = '0;
   logic [7:0] rdata;
   logic [3:0] mux;
   logic pwr, start, dn, th;
   logic [3:0] seq [4] = '{4'h4, 4'h5, 4'h2, 4'h3};
   logic [2:0] hit [5] = '{3'h4, 3'h1, 3'h2, 3'h0, 3'h0};
   logic [15:0] tv [3] = '{16'h0005, 16'h0008, 16'h0030};
   logic te [3] = '{1'h1, 1'h0, 1'h1};
   int fails = 0;
   int checks = 0;
   int n;
   capsns_sequencer #(.NUM_CHANNELS(12)) u_capsns_sequencer (
      .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .sfr_req(req), .sfr_rdata(rdata),
      .tmr_ovf(tmr), .afe_in(afe), .afe_power_on(pwr), .afe_start(start), .mux_sel(mux),
      .done_event(dn), .thr_event(th));
   initial
   begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic cmp(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   // strobe stays high until the next rd, feed, quiet or tp lowers it (wait_start does not), so it never toggles twice a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{a, 1'h1, d};
      tick;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
      req = '{a, 1'h0, 8'h00};
      tick;
      cmp(rdata, e, what);
   endtask
   task automatic wait_start;
      for (int i = 0; i < 60 && start !== 1'h1; i++)
         tick;
      cmp(start, 1'h1, "start");
   endtask
   task automatic feed(input logic [15:0] v);
      req.wr = 1'h0;
      tick;
      afe = '{1'h1, v};
      tick;
      afe.done = 1'h0;
   endtask
   task automatic quiet(input int k);
      req.wr = 1'h0;
      repeat (k)
      begin
         cmp(start, 1'h0, "no start");
         tick;
      end
   endtask
   task automatic tp(input logic [2:0] t);
      req.wr = 1'h0;
      tmr = t;
      tick;
      tmr = 3'h0;
   endtask
   task automatic wrap_up;
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      // the whole sequence needs well under a thousand cycles
      #(40 * 20000);
      fails++;
      wrap_up;
   end
   initial
   begin
      repeat (3)
         tick;
      reset = 1'h0;
      // a write under a low clock enable must leave the register untouched
      clk_en = 1'h0;
      wr(CFG, 8'h11);
      clk_en = 1'h1;
      rd(CFG, 16'h0000, "cfg reset");
      rd(8'h00, 16'h0000, "unmapped");
      wr(CFG, 8'hFF);
      rd(CFG, 16'h0077, "cfg mask");
      wr(CTL, 8'h10);
      quiet(6);
      wr(CTL, 8'h80);
      rd(CTL, 16'h0080, "enable");
      cmp(pwr, 1'h1, "power");
      for (int k = 0; k < 7; k++)
      begin
         n = (k == 0 || k == 6) ? 1 : 2 << k;
         wr(CFG, 8'(k));
         wr(CTL, 8'h90);
         wait_start;
         rd(CTL, 16'h0090, "busy");
         for (int i = 0; i < n; i++)
         begin
            feed(16'(2 * i));
            cmp(dn, 16'(i == n - 1), "done");
            if (i < n - 1)
               wait_start;
         end
         rd(CTL, 16'h00A0 | 16'(k == 0) << 3, "idle");
         rd(`CAPSNS_ADDR_RES_LO, 16'(n - 1), "average");
      end
      wr(`CAPSNS_ADDR_THR_LO, 8'h10);
      for (int j = 0; j < 3; j++)
      begin
         wr(CTL, 8'h90);
         wait_start;
         feed(tv[j]);
         cmp(th, te[j], "threshold");
      end
      // modes 4 and 5 have no matching timer and must ignore every trigger
      for (int m = 0; m < 5; m++)
      begin
         wr(CFG, 8'(m + 1) << 4);
         tp(~hit[m]);
         quiet(4);
         if (hit[m] != 3'h0)
         begin
            tp(hit[m]);
            wait_start;
            feed(16'h0000);
         end
      end
      wr(CFG, 8'h60);
      wr(CTL, 8'h90);
      repeat (3)
      begin
         wait_start;
         feed(16'h0000);
      end
      wait_start;
      wr(CTL, 8'h80);
      feed(16'h0000);
      quiet(8);
      wr(`CAPSNS_ADDR_SCAN, 8'h52);
      wr(`CAPSNS_ADDR_MUX, 8'h0C);
      cmp(mux, 16'h0000, "mux refused");
      wr(`CAPSNS_ADDR_MUX, 8'h04);
      cmp(mux, 16'h0004, "mux write");
      wr(CFG, 8'h70);
      wr(CTL, 8'h90);
      foreach (seq[s])
      begin
         wait_start;
         cmp(mux, seq[s], "scan");
         feed(16'h0000);
      end
      wait_start;
      wr(CTL, 8'h80);
      feed(16'h0000);
      wr(CFG, 8'h00);
      wr(CTL, 8'h90);
      wait_start;
      wr(CTL, 8'h10);
      quiet(4);
      cmp(pwr, 1'h0, "abort power");
      rd(CTL, 16'h0000, "abort");
      wrap_up;
   end
endmodule
`default_nettype wire
